// File: logic/sfc_dev_end.sv
// Device end: identifier, user serial number and low power commands
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_cfg.svh"
module sfc_dev_end
    import sfc_pkg::*;
#(
    // Value is arbitrary
    parameter logic [63:0] FACTORY_UID = 64'h1122_3344_5566_7788,
    parameter int DEEP_ENTRY_CYC = `SFC_CYC_DN(`SFC_DEEP_SLEEP_ENTRY_DELAY_NS),
    parameter int DEEP_PULSE_CYC = `SFC_CYC_UP(`SFC_DEEP_SLEEP_WAKE_PULSE_WIDTH_NS),
    parameter int DEEP_EXIT_CYC = `SFC_CYC_DN(`SFC_DEEP_SLEEP_EXIT_DELAY_NS),
    parameter int HIB_ENTRY_CYC = `SFC_CYC_DN(`SFC_HIBERNATE_ENTRY_DELAY_NS),
    parameter int HIB_EXIT_CYC = `SFC_CYC_DN(`SFC_HIBERNATE_EXIT_DELAY_NS)
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Link
    sfc_spi_if.dev spi,
    // User side status
    output logic [63:0] user_serial_number,
    output logic serial_locked,
    output logic sleeping,
    output logic waking
);
    if (DEEP_ENTRY_CYC < 1 || DEEP_PULSE_CYC < 1 || DEEP_EXIT_CYC < 1 ||
        HIB_ENTRY_CYC < 1 || HIB_EXIT_CYC < 1) begin : g_bad_timing
        $error("sfc_dev_end: every delay must be at least one cycle");
    end

    logic cs_m, cs_s, cs_p;
    logic sck_m, sck_s, sck_p;
    logic si_m, si_s;
    logic cs_fall, cs_rise, sck_rise, sck_fall, awake, sel, byte_done;
    logic [7:0] rx_sh, rx_byte, cur_byte;
    logic [2:0] bit_cnt, out_bit, rd_idx;
    logic [3:0] wr_idx;
    logic [63:0] shadow, cur_word;
    logic rd_src, wel, hib;
    logic [31:0] tmr, low_cnt;
    sfc_cmd_t cmd;
    sfc_pend_t pend;
    sfc_pwr_t pwr;

    // Pin synchronisers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_p <= 1'b1;
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_p <= 1'b0;
            si_m <= 1'b0;
            si_s <= 1'b0;
        end else if (clk_en) begin
            cs_m <= spi.cs_n;
            cs_s <= cs_m;
            cs_p <= cs_s;
            sck_m <= spi.sck;
            sck_s <= sck_m;
            sck_p <= sck_s;
            si_m <= spi.mosi;
            si_s <= si_m;
        end
    end

    assign cs_fall = cs_p & ~cs_s;
    assign cs_rise = ~cs_p & cs_s;
    assign sck_rise = sck_s & ~sck_p;
    assign sck_fall = sck_p & ~sck_s;
    assign awake = (pwr == PW_ACTIVE);
    assign sel = awake & ~cs_s;
    assign rx_byte = {rx_sh[6:0], si_s};
    assign byte_done = sel & sck_rise & (bit_cnt == 3'h7);
    assign cur_word = rd_src ? user_serial_number : FACTORY_UID;
    assign cur_byte = cur_word[{rd_idx, 3'b000} +: 8];
    assign sleeping = (pwr == PW_ASLEEP);
    assign waking = (pwr == PW_WAKE);

    // Input shifter, sampled on rising clock edges
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_sh <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (clk_en) begin
            if (cs_fall) begin
                bit_cnt <= 3'h0;
            end else if (sel & sck_rise) begin
                rx_sh <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    // Opcode decode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd <= CM_IGNORE;
            pend <= PD_NONE;
            rd_src <= 1'b0;
        end else if (clk_en) begin
            if (!awake) begin
                cmd <= CM_IGNORE;
                pend <= PD_NONE;
            end else if (cs_fall) begin
                cmd <= CM_OPCODE;
                pend <= PD_NONE;
            end else if (byte_done && cmd == CM_OPCODE) begin
                cmd <= CM_IGNORE;
                case (rx_byte)
                    `SFC_OP_READ_UID: begin
                        cmd <= CM_READ;
                        rd_src <= 1'b0;
                    end
                    `SFC_OP_READ_SERIAL: begin
                        cmd <= CM_READ;
                        rd_src <= 1'b1;
                    end
                    `SFC_OP_WRITE_SERIAL: begin
                        if (wel && !serial_locked) begin
                            cmd <= CM_WRITE;
                        end
                    end
                    `SFC_OP_WEL_SET: begin
                        pend <= PD_WEL;
                    end
                    `SFC_OP_DEEP_SLEEP: begin
                        pend <= PD_DEEP;
                    end
                    `SFC_OP_HIBERNATE: begin
                        pend <= PD_HIB;
                    end
                    default: begin
                        pend <= PD_NONE;
                    end
                endcase
            end
        end
    end

    // Write enable lasts exactly one following frame
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wel <= 1'b0;
        end else if (clk_en) begin
            if (cs_rise && awake) begin
                wel <= (pend == PD_WEL);
            end
        end
    end

    // Read output, driven on falling clock edges
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_bit <= 3'h0;
            rd_idx <= 3'h0;
            spi.miso <= 1'b0;
            spi.miso_oe <= 1'b0;
        end else if (clk_en) begin
            if (cs_rise || !awake) begin
                spi.miso <= 1'b0;
                spi.miso_oe <= 1'b0;
            end else if (cs_fall) begin
                out_bit <= 3'h0;
                rd_idx <= 3'h0;
            end else if (sel && sck_fall && cmd == CM_READ) begin
                spi.miso <= cur_byte[~out_bit];
                spi.miso_oe <= 1'b1;
                out_bit <= out_bit + 3'h1;
                if (out_bit == 3'h7) begin
                    rd_idx <= rd_idx + 3'h1;
                end
            end
        end
    end

    // Serial number staging and commit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shadow <= `SFC_SERIAL_RESET;
            wr_idx <= 4'h0;
            user_serial_number <= `SFC_SERIAL_RESET;
            serial_locked <= 1'b0;
        end else if (clk_en) begin
            if (byte_done && cmd == CM_OPCODE) begin
                shadow <= user_serial_number;
                wr_idx <= 4'h0;
            end else if (byte_done && cmd == CM_WRITE && wr_idx != `SFC_MAX_BYTES) begin
                shadow[{wr_idx[2:0], 3'b000} +: 8] <= rx_byte;
                wr_idx <= wr_idx + 4'h1;
            end
            if (cs_rise && awake && cmd == CM_WRITE && wr_idx != 4'h0) begin
                user_serial_number <= shadow;
                serial_locked <= 1'b1;
            end
        end
    end

    // Length of the current select low pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt <= 32'h0;
        end else if (clk_en) begin
            if (cs_p) begin
                low_cnt <= 32'h0;
            end else if (low_cnt != 32'(DEEP_PULSE_CYC)) begin
                low_cnt <= low_cnt + 32'h1;
            end
        end
    end

    // Power state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr <= PW_ACTIVE;
            hib <= 1'b0;
            tmr <= 32'h0;
        end else if (clk_en) begin
            unique case (pwr)
                PW_ACTIVE: begin
                    if (cs_rise && pend == PD_DEEP) begin
                        pwr <= PW_ENTER;
                        hib <= 1'b0;
                        tmr <= 32'(DEEP_ENTRY_CYC - 1);
                    end else if (cs_rise && pend == PD_HIB) begin
                        pwr <= PW_ENTER;
                        hib <= 1'b1;
                        tmr <= 32'(HIB_ENTRY_CYC - 1);
                    end
                end
                PW_ENTER: begin
                    if (tmr == 32'h0) begin
                        pwr <= PW_ASLEEP;
                    end else begin
                        tmr <= tmr - 32'h1;
                    end
                end
                PW_ASLEEP: begin
                    if (hib && cs_fall) begin
                        pwr <= PW_WAKE;
                        tmr <= 32'(HIB_EXIT_CYC - 1);
                    end else if (!hib && cs_rise && low_cnt == 32'(DEEP_PULSE_CYC)) begin
                        pwr <= PW_WAKE;
                        tmr <= 32'(DEEP_EXIT_CYC - 1);
                    end
                end
                PW_WAKE: begin
                    if (tmr == 32'h0) begin
                        pwr <= PW_ACTIVE;
                    end else begin
                        tmr <= tmr - 32'h1;
                    end
                end
            endcase
        end
    end
endmodule // sfc_dev_end
`default_nettype wire

// File: logic/sfc_cfg.svh
// Constants shared by both ends of the serial id and power command link
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// Opcodes
`define SFC_OP_READ_UID 8'h4c
`define SFC_OP_WRITE_SERIAL 8'hc2
`define SFC_OP_READ_SERIAL 8'hc3
`define SFC_OP_WEL_SET 8'h06
`define SFC_OP_DEEP_SLEEP 8'hba
`define SFC_OP_HIBERNATE 8'hb9

// Reset values
`define SFC_SERIAL_RESET 64'h0000_0000_0000_0000

// Timing in ns and conversion to ref_clk cycles
`define SFC_CLK_MHZ 50
`define SFC_DEEP_SLEEP_ENTRY_DELAY_NS 3000
`define SFC_DEEP_SLEEP_WAKE_PULSE_WIDTH_NS 1000
`define SFC_DEEP_SLEEP_EXIT_DELAY_NS 10000
`define SFC_HIBERNATE_ENTRY_DELAY_NS 3000
`define SFC_HIBERNATE_EXIT_DELAY_NS 450000
`define SFC_CYC_UP(ns) ((((ns) * `SFC_CLK_MHZ) + 999) / 1000)
`define SFC_CYC_DN(ns) (((ns) * `SFC_CLK_MHZ) / 1000)

// Host link timing in ref_clk cycles and receive buffer depth in bytes
`define SFC_HOST_HALF_CYC 4
`define SFC_HOST_SAMPLE_OFS 2
`define SFC_HOST_GAP_CYC 8
`define SFC_HOST_BUF_DEPTH 2

// Host register map and command fields
`define SFC_REG_CMD 4'h0
`define SFC_REG_TX_LO 4'h4
`define SFC_REG_TX_HI 4'h8
`define SFC_REG_STATUS 4'hc
`define SFC_CMD_OP_MSB 7
`define SFC_CMD_CNT_MSB 11
`define SFC_CMD_CNT_LSB 8
`define SFC_CMD_RD_BIT 12
`define SFC_CMD_PULSE_BIT 13
`define SFC_MAX_BYTES 4'h8

`endif

// File: logic/sfc_pkg.sv
// Types shared by both ends of the serial id and power command link
package sfc_pkg;
    typedef enum logic [1:0] {
        PW_ACTIVE = 2'b00,
        PW_ENTER = 2'b01,
        PW_ASLEEP = 2'b11,
        PW_WAKE = 2'b10
    } sfc_pwr_t;
    typedef enum logic [1:0] {
        CM_OPCODE = 2'b00,
        CM_READ = 2'b01,
        CM_WRITE = 2'b11,
        CM_IGNORE = 2'b10
    } sfc_cmd_t;
    typedef enum logic [1:0] {
        PD_NONE = 2'b00,
        PD_WEL = 2'b01,
        PD_DEEP = 2'b11,
        PD_HIB = 2'b10
    } sfc_pend_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SHIFT = 2'b01,
        H_PULSE = 2'b11,
        H_GAP = 2'b10
    } sfc_hst_t;
endpackage

// File: logic/sfc_spi_if.sv
// Serial link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface sfc_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic so_level;
    // Released serial output reads low
    assign so_level = miso_oe & miso;
    modport dev(input cs_n, input sck, input mosi, output miso, output miso_oe);
    modport host(output cs_n, output sck, output mosi, input so_level);
endinterface
`default_nettype wire

// File: logic/sfc_host_end.sv
// Host end: register driven link master with receive buffer
`timescale 1ns/1ps
`default_nettype none
`include "sfc_cfg.svh"
module sfc_host_end
    import sfc_pkg::*;
#(
    parameter int HALF_CYC = `SFC_HOST_HALF_CYC,
    parameter int SAMPLE_OFS = `SFC_HOST_SAMPLE_OFS,
    parameter int PULSE_CYC = `SFC_CYC_UP(`SFC_DEEP_SLEEP_WAKE_PULSE_WIDTH_NS),
    parameter int GAP_CYC = `SFC_HOST_GAP_CYC,
    parameter int BUF_DEPTH = `SFC_HOST_BUF_DEPTH
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Link
    sfc_spi_if.host spi,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Received byte stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready
);
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    if (HALF_CYC < 2 || SAMPLE_OFS < 1 || SAMPLE_OFS >= HALF_CYC || PULSE_CYC < 1 ||
        GAP_CYC < 1 || BUF_DEPTH != (1 << PW)) begin : g_bad_param
        $error("sfc_host_end: unsupported timing or buffer depth");
    end

    sfc_hst_t st;
    logic so_m, so_s, start, stall, push, pop, in_ready, rd_mode;
    logic [15:0] ph;
    logic [6:0] bcnt;
    logic [3:0] cnt;
    logic [7:0] op, rx_sh;
    logic [63:0] tx_data, tx_swap;
    logic [71:0] tx_sh;
    logic [7:0] mem [BUF_DEPTH];
    logic [PW-1:0] wp, rp;
    logic [PW:0] fill;

    // Serial output from the device crosses in here
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            so_m <= 1'b0;
            so_s <= 1'b0;
        end else if (clk_en) begin
            so_m <= spi.so_level;
            so_s <= so_m;
        end
    end

    // Byte 0 leaves first after the opcode
    always_comb begin
        tx_swap = 64'h0;
        for (int i = 0; i < 8; i++) begin
            tx_swap[8 * (7 - i) +: 8] = tx_data[8 * i +: 8];
        end
    end

    assign start = wr_en && addr == `SFC_REG_CMD && st == H_IDLE;
    assign in_ready = (fill != (PW + 1)'(BUF_DEPTH));
    assign stall = rd_mode && bcnt[2:0] == 3'h0 && bcnt[6:3] != 4'h0 && ph == 16'h0 && !in_ready;
    assign push = st == H_SHIFT && ph == 16'(2 * HALF_CYC - 1) && rd_mode && bcnt[2:0] == 3'h7
        && bcnt[6:3] != 4'h0;
    assign rx_valid = (fill != '0);
    assign rx_data = mem[rp];
    assign pop = rx_valid & rx_ready;

    // Software registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_data <= 64'h0;
            op <= 8'h00;
            cnt <= 4'h0;
            rd_mode <= 1'b0;
            rdata <= 32'h0;
        end else if (clk_en) begin
            if (wr_en && addr == `SFC_REG_TX_LO) begin
                tx_data[31:0] <= wdata;
            end
            if (wr_en && addr == `SFC_REG_TX_HI) begin
                tx_data[63:32] <= wdata;
            end
            if (start) begin
                op <= wdata[`SFC_CMD_OP_MSB:0];
                cnt <= (wdata[`SFC_CMD_CNT_MSB:`SFC_CMD_CNT_LSB] > `SFC_MAX_BYTES) ?
                    `SFC_MAX_BYTES : wdata[`SFC_CMD_CNT_MSB:`SFC_CMD_CNT_LSB];
                rd_mode <= wdata[`SFC_CMD_RD_BIT];
            end
            rdata <= 32'h0;
            if (rd_en) begin
                unique case (addr)
                    `SFC_REG_CMD: rdata <= {18'h0, 1'b0, rd_mode, cnt, op};
                    `SFC_REG_TX_LO: rdata <= tx_data[31:0];
                    `SFC_REG_TX_HI: rdata <= tx_data[63:32];
                    `SFC_REG_STATUS: rdata <= {28'h0, 3'(fill), st != H_IDLE};
                    default: rdata <= 32'h0;
                endcase
            end
        end
    end

    // Link sequencer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= H_IDLE;
            spi.cs_n <= 1'b1;
            spi.sck <= 1'b0;
            spi.mosi <= 1'b0;
            tx_sh <= 72'h0;
            bcnt <= 7'h0;
            ph <= 16'h0;
            rx_sh <= 8'h00;
        end else if (clk_en) begin
            unique case (st)
                H_IDLE: begin
                    ph <= 16'h0;
                    bcnt <= 7'h0;
                    if (start && wdata[`SFC_CMD_PULSE_BIT]) begin
                        st <= H_PULSE;
                        spi.cs_n <= 1'b0;
                    end else if (start) begin
                        st <= H_SHIFT;
                        spi.cs_n <= 1'b0;
                        tx_sh <= {wdata[`SFC_CMD_OP_MSB:0], tx_swap};
                        spi.mosi <= wdata[`SFC_CMD_OP_MSB];
                    end
                end
                H_SHIFT: begin
                    if (!stall) begin
                        ph <= (ph == 16'(2 * HALF_CYC - 1)) ? 16'h0 : ph + 16'h1;
                    end
                    if (ph == 16'(HALF_CYC - 1)) begin
                        spi.sck <= 1'b1;
                    end
                    if (ph == 16'(HALF_CYC - 1 + SAMPLE_OFS)) begin
                        rx_sh <= {rx_sh[6:0], so_s};
                    end
                    if (ph == 16'(2 * HALF_CYC - 1)) begin
                        spi.sck <= 1'b0;
                        tx_sh <= {tx_sh[70:0], 1'b0};
                        spi.mosi <= tx_sh[70];
                        bcnt <= bcnt + 7'h1;
                        if (bcnt == {cnt, 3'h7}) begin
                            st <= H_GAP;
                            spi.cs_n <= 1'b1;
                            spi.mosi <= 1'b0;
                        end
                    end
                end
                H_PULSE: begin
                    ph <= ph + 16'h1;
                    if (ph == 16'(PULSE_CYC - 1)) begin
                        st <= H_GAP;
                        spi.cs_n <= 1'b1;
                        ph <= 16'h0;
                    end
                end
                H_GAP: begin
                    ph <= ph + 16'h1;
                    if (ph == 16'(GAP_CYC - 1)) begin
                        st <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive buffer
    for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_ent
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                mem[i] <= 8'h00;
            end else if (clk_en && push && wp == PW'(i)) begin
                mem[i] <= rx_sh;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp <= '0;
            rp <= '0;
            fill <= '0;
        end else if (clk_en) begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule // sfc_host_end
`default_nettype wire

// File: verif/sfc_assertions.sv
// Assertions on the link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module sfc_assertions #(
    parameter int HIB_EXIT_CYC = 40
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic miso,
    input wire logic miso_oe,
    // Device state
    input wire logic sleeping,
    input wire logic waking
);
    logic [15:0] wake_cnt;
    // Length of the current wake period
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_cnt <= 16'h0000;
        end else begin
            wake_cnt <= waking ? wake_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    property p_release;
        cs_n [*5] |-> !miso_oe;
    endproperty
    property p_oe_sel;
        $rose(miso_oe) |-> !cs_n;
    endproperty
    property p_miso_hold;
        sck && $past(sck) && miso_oe && $past(miso_oe) |-> $stable(miso);
    endproperty
    property p_sck_idle;
        cs_n && $past(cs_n) |-> !sck;
    endproperty
    property p_sleep_off;
        sleeping |-> !miso_oe;
    endproperty
    property p_wake_off;
        waking |-> !miso_oe;
    endproperty
    property p_enter;
        $rose(sleeping) |-> cs_n;
    endproperty
    property p_wake_src;
        $rose(waking) |-> $past(sleeping);
    endproperty
    property p_wake_len;
        wake_cnt <= HIB_EXIT_CYC + 2;
    endproperty
    property p_wake_end;
        $fell(waking) |-> !sleeping;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected");
    a_oe_sel: assert property (p_oe_sel) else $error("output enabled while deselected");
    a_miso_hold: assert property (p_miso_hold) else $error("output moved while clock high");
    a_sck_idle: assert property (p_sck_idle) else $error("clock not idle low");
    a_sleep_off: assert property (p_sleep_off) else $error("output driven asleep");
    a_wake_off: assert property (p_wake_off) else $error("output driven waking");
    a_enter: assert property (p_enter) else $error("sleep entered while selected");
    a_wake_src: assert property (p_wake_src) else $error("wake without sleep");
    a_wake_len: assert property (p_wake_len) else $error("wake period too long");
    a_wake_end: assert property (p_wake_end) else $error("still asleep after wake");
    c_sleep: cover property ($rose(sleeping));
    c_wake: cover property ($fell(waking));
    c_read: cover property ($rose(miso_oe));
endmodule // sfc_assertions
`default_nettype wire

// File: verif/tb.sv
// Testbench joining host end and device end
`timescale 1ns/1ps
`default_nettype none
`include "sfc_cfg.svh"
module tb;
    localparam logic [63:0] UID = 64'h0f1e_2d3c_4b5a_6978;
    localparam int ENT_CYC = 10;
    localparam int PUL_CYC = 8;
    localparam int DEX_CYC = 20;
    localparam int HEX_CYC = 40;
    logic ref_clk, arst_n, wr_en, rd_en, rx_ready, rx_valid, hold;
    logic clk_en = 1'b1;
    logic sleeping, waking, locked;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] rx_data, sr, last_op;
    logic [63:0] sn, v;
    int seed = 20529;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int nb = 0;
    logic [7:0] expq[$];
    sfc_spi_if spi();
    sfc_dev_end #(.FACTORY_UID(UID), .DEEP_ENTRY_CYC(ENT_CYC), .DEEP_PULSE_CYC(PUL_CYC),
        .DEEP_EXIT_CYC(DEX_CYC), .HIB_ENTRY_CYC(ENT_CYC), .HIB_EXIT_CYC(HEX_CYC)) sfc_dev_end_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .spi(spi.dev),
        .user_serial_number(sn), .serial_locked(locked), .sleeping(sleeping), .waking(waking));
    sfc_host_end #(.PULSE_CYC(PUL_CYC)) sfc_host_end_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .clk_en(clk_en), .spi(spi.host), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready));
    sfc_assertions #(.HIB_EXIT_CYC(HEX_CYC)) sfc_assertions_inst (.ref_clk(ref_clk),
        .arst_n(arst_n), .cs_n(spi.cs_n), .sck(spi.sck), .miso(spi.miso),
        .miso_oe(spi.miso_oe), .sleeping(sleeping), .waking(waking));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [3:0] n, input logic r, input logic p,
        input logic [63:0] tx);
        last_op = op;
        wr(`SFC_REG_TX_LO, tx[31:0]);
        wr(`SFC_REG_TX_HI, tx[63:32]);
        wr(`SFC_REG_CMD, {18'h0, p, r, n, op});
    endtask
    task automatic idle();
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) rd(`SFC_REG_STATUS, s);
        for (int i = 0; i < 300 && expq.size() > 0; i++) @(posedge ref_clk);
        chk("busy", s[0], 1'b0);
        chk("drain", 64'(expq.size()), 64'h0);
    endtask
    task automatic run(input logic [7:0] op, input logic [63:0] e);
        for (int i = 0; i < 8; i++) expq.push_back(e[8*i+:8]);
        cmd(op, 4'h8, 1'b1, 1'b0, 64'h0);
        idle();
    endtask
    task automatic wake_wait();
        for (int i = 0; i < 200 && waking !== 1'b0; i++) @(posedge ref_clk);
        chk("awake", {sleeping, waking}, 2'b00);
    endtask
    // Received bytes against the noted order
    always @(posedge ref_clk) begin
        if (clk_en === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1)
            chk("rx_byte", rx_data, expq.size() > 0 ? 64'(expq.pop_front()) : 64'hx);
    end
    // Opcode bits on the wire
    always @(negedge spi.cs_n or posedge spi.sck) begin
        if (spi.cs_n === 1'b0 && spi.sck === 1'b1) begin
            sr = {sr[6:0], spi.mosi};
            nb++;
            if (nb == 8) chk("opcode", sr, last_op);
        end else begin
            nb = 0;
        end
    end
    always @(posedge ref_clk) rx_ready <= !hold && ($random(seed) % 4 != 0);
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        {arst_n, wr_en, rd_en, hold, addr, wdata, last_op} = '0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(4'h2, v[31:0]);
        chk("unmapped", v[31:0], 32'h0);
        rd(`SFC_REG_STATUS, v[31:0]);
        chk("status", v[31:0], 32'h0);
        chk("sn_reset", sn, `SFC_SERIAL_RESET);
        run(`SFC_OP_READ_SERIAL, `SFC_SERIAL_RESET);
        run(`SFC_OP_READ_UID, UID);
        $display("test reads done");
        for (int i = 0; i < 8; i++) expq.push_back(UID[8*i+:8]);
        hold = 1'b1;
        cmd(`SFC_OP_READ_UID, 4'h8, 1'b1, 1'b0, 64'h0);
        repeat (400) @(posedge ref_clk);
        rd(`SFC_REG_STATUS, v[31:0]);
        chk("full", v[3:0], 4'h5);
        rd(`SFC_REG_CMD, v[31:0]);
        chk("cmd_reg", v[31:0], {18'h0, 1'b0, 1'b1, 4'h8, `SFC_OP_READ_UID});
        hold = 1'b0;
        idle();
        $display("test stall done");
        for (int i = 0; i < 8; i++) expq.push_back(UID[8*i+:8]);
        cmd(`SFC_OP_READ_UID, 4'h8, 1'b1, 1'b0, 64'h0);
        repeat (100) @(posedge ref_clk);
        clk_en <= 1'b0;
        @(posedge ref_clk);
        #1 v[4:0] = {spi.cs_n, spi.sck, spi.mosi, spi.miso, spi.miso_oe};
        repeat (40) @(posedge ref_clk);
        chk("freeze", {spi.cs_n, spi.sck, spi.mosi, spi.miso, spi.miso_oe}, v[4:0]);
        clk_en <= 1'b1;
        idle();
        $display("test freeze done");
        v = {$random(seed), $random(seed)};
        cmd(`SFC_OP_WRITE_SERIAL, 4'h8, 1'b0, 1'b0, v);
        idle();
        chk("no_enable", sn, `SFC_SERIAL_RESET);
        chk("unlocked", locked, 1'b0);
        cmd(`SFC_OP_WEL_SET, 4'h0, 1'b0, 1'b0, 64'h0);
        idle();
        cmd(`SFC_OP_WRITE_SERIAL, 4'h8, 1'b0, 1'b0, v);
        idle();
        chk("serial", sn, v);
        chk("locked", locked, 1'b1);
        run(`SFC_OP_READ_SERIAL, v);
        cmd(`SFC_OP_WEL_SET, 4'h0, 1'b0, 1'b0, 64'h0);
        idle();
        cmd(`SFC_OP_WRITE_SERIAL, 4'h8, 1'b0, 1'b0, ~v);
        idle();
        chk("one_time", sn, v);
        $display("test serial done");
        cmd(`SFC_OP_DEEP_SLEEP, 4'h0, 1'b0, 1'b0, 64'h0);
        idle();
        repeat (20) @(posedge ref_clk);
        chk("deep", sleeping, 1'b1);
        run(`SFC_OP_READ_UID, 64'h0);
        wake_wait();
        run(`SFC_OP_READ_UID, UID);
        $display("test deep done");
        cmd(`SFC_OP_HIBERNATE, 4'h0, 1'b0, 1'b0, 64'h0);
        idle();
        repeat (20) @(posedge ref_clk);
        chk("hib", sleeping, 1'b1);
        cmd(8'h00, 4'h0, 1'b0, 1'b1, 64'h0);
        idle();
        chk("hib_wake", waking, 1'b1);
        wake_wait();
        run(`SFC_OP_READ_UID, UID);
        $display("test hibernate done");
        results();
    end
endmodule // tb
`default_nettype wire
